// File: rtl/alu_branch_pkg.sv
`default_nettype none
package alu_branch_pkg;

	// Major opcodes of the custom instruction groups
	localparam logic [6:0] OPC_ALU = 7'h2B;
	localparam logic [6:0] OPC_NORM = 7'h5B;
	localparam logic [6:0] OPC_BRANCH_IMM = 7'h0B;

	// Function codes
	localparam logic [2:0] F3_ALU = 3'h3;
	localparam logic [2:0] F3_ADD_SHIFT = 3'h2;
	localparam logic [2:0] F3_SUB_SHIFT = 3'h3;
	localparam logic [2:0] F3_BRANCH_EQ = 3'h6;
	localparam logic [2:0] F3_BRANCH_NE = 3'h7;
	localparam logic [6:0] F7_SLE = 7'h29;
	localparam logic [6:0] F7_SLEU = 7'h2A;
	localparam logic [6:0] F7_MIN = 7'h2B;
	localparam logic [6:0] F7_MINU = 7'h2C;
	localparam logic [6:0] F7_MAX = 7'h2D;
	localparam logic [6:0] F7_MAXU = 7'h2E;
	localparam logic [6:0] F7_CLIP = 7'h38;
	localparam logic [6:0] F7_CLIPU = 7'h39;
	localparam logic [6:0] F7_CLIPR = 7'h3A;
	localparam logic [6:0] F7_CLIPUR = 7'h3B;
	localparam logic [3:0] F7_REGSHIFT_HI = 4'h8; // funct7[6:3] of 0x40..0x47

	// Output reset values
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam logic [31:0] TARGET_RST = 32'h0000_0000;

	// Decoded operation; shift groups are contiguous, variant in low 2 bits of the offset from OP_ADD_SHIFT_SIGNED
	typedef enum logic [4:0] {
		OP_NONE = 5'b00000,
		OP_SIGNED_LE_COMPARE = 5'b00001,
		OP_UNSIGNED_LE_COMPARE = 5'b00010,
		OP_SIGNED_MINIMUM = 5'b00011,
		OP_UNSIGNED_MINIMUM = 5'b00100,
		OP_SIGNED_MAXIMUM = 5'b00101,
		OP_UNSIGNED_MAXIMUM = 5'b00110,
		OP_SIGNED_CLIP_IMM = 5'b00111,
		OP_UNSIGNED_CLIP_IMM = 5'b01000,
		OP_SIGNED_CLIP_REG = 5'b01001,
		OP_UNSIGNED_CLIP_REG = 5'b01010,
		OP_ADD_SHIFT_SIGNED = 5'b01011,
		OP_ADD_SHIFT_UNSIGNED = 5'b01100,
		OP_ADD_ROUND_SHIFT_SIGNED = 5'b01101,
		OP_ADD_ROUND_SHIFT_UNSIGNED = 5'b01110,
		OP_SUB_SHIFT_SIGNED = 5'b01111,
		OP_SUB_SHIFT_UNSIGNED = 5'b10000,
		OP_SUB_ROUND_SHIFT_SIGNED = 5'b10001,
		OP_SUB_ROUND_SHIFT_UNSIGNED = 5'b10010,
		OP_ADD_REGSHIFT_SIGNED = 5'b10011,
		OP_ADD_REGSHIFT_UNSIGNED = 5'b10100,
		OP_ADD_ROUND_REGSHIFT_SIGNED = 5'b10101,
		OP_ADD_ROUND_REGSHIFT_UNSIGNED = 5'b10110,
		OP_SUB_REGSHIFT_SIGNED = 5'b10111,
		OP_SUB_REGSHIFT_UNSIGNED = 5'b11000,
		OP_SUB_ROUND_REGSHIFT_SIGNED = 5'b11001,
		OP_SUB_ROUND_REGSHIFT_UNSIGNED = 5'b11010,
		OP_BRANCH_EQUAL_SMALL_IMM = 5'b11011,
		OP_BRANCH_NOTEQUAL_SMALL_IMM = 5'b11100
	} op_e;

	// Decoded instruction as handed to execute
	typedef struct packed {
		logic valid;
		logic claimed;
		logic illegal;
		op_e op;
		logic [4:0] rd_idx;
		logic [4:0] rs1_idx;
		logic [4:0] rs2_idx;
		logic rs2_is_reg;
		logic rd_is_src;
		logic [4:0] small_imm;
		logic [4:0] shift_amount_immediate;
	} dec_s;

	localparam dec_s DEC_RST = '0;

endpackage
`default_nettype wire

// File: rtl/norm_alu_unit.sv
`timescale 1ns/1ps
`default_nettype none
module norm_alu_unit import alu_branch_pkg::*; (
	input wire op_e op_i,
	input wire logic [31:0] a_i,
	input wire logic [31:0] b_i,
	input wire logic [31:0] rd_i,
	input wire logic [4:0] compare_small_immediate_i,
	input wire logic [4:0] shamt_i,
	output logic [31:0] res_o
);

	////////////////////////////////////////////////////////////////////////
	// Compare, min/max, clip and normalising add/sub
	always_comb begin
		logic [4:0] idx;
		logic regsh;
		logic sub;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] rnd;
		logic [31:0] sum;
		logic [31:0] hi;
		logic [4:0] sh;
		idx = 5'(op_i - OP_ADD_SHIFT_SIGNED);
		regsh = idx[3]; // Groups of four: imm add, imm sub, reg add, reg sub
		sub = idx[2];
		x = regsh ? rd_i : a_i; // RULE17
		y = regsh ? a_i : b_i; // RULE17
		sh = regsh ? b_i[4:0] : shamt_i; // RULE17
		rnd = (sh == 5'h00) ? 32'h0 : (32'h1 << (sh - 5'h01)); // RULE15
		sum = sub ? (x - y + rnd) : (x + y + rnd);
		if (!idx[1])
			sum = sub ? (x - y) : (x + y);
		hi = (compare_small_immediate_i == 5'h00) ? 32'h0 : ((32'h1 << (compare_small_immediate_i - 5'h01)) - 32'h1);
		if (op_i == OP_SIGNED_CLIP_REG || op_i == OP_UNSIGNED_CLIP_REG)
			hi = b_i; // RULE5
		res_o = 32'h0;
		case (op_i)
			OP_SIGNED_LE_COMPARE: res_o = {31'h0, $signed(a_i) <= $signed(b_i)};
			OP_UNSIGNED_LE_COMPARE: res_o = {31'h0, a_i <= b_i};
			OP_SIGNED_MINIMUM: res_o = ($signed(a_i) < $signed(b_i)) ? a_i : b_i;
			OP_UNSIGNED_MINIMUM: res_o = (a_i < b_i) ? a_i : b_i;
			OP_SIGNED_MAXIMUM: res_o = ($signed(a_i) > $signed(b_i)) ? a_i : b_i;
			OP_UNSIGNED_MAXIMUM: res_o = (a_i > b_i) ? a_i : b_i;
			OP_SIGNED_CLIP_IMM, OP_SIGNED_CLIP_REG: begin
				// Low bound is -(hi+1), i.e. the inverse of hi
				if ($signed(a_i) <= $signed(~hi))
					res_o = ~hi; // RULE16
				else if ($signed(a_i) >= $signed(hi))
					res_o = hi;
				else
					res_o = a_i;
			end
			OP_UNSIGNED_CLIP_IMM, OP_UNSIGNED_CLIP_REG: begin
				if ($signed(a_i) <= 0)
					res_o = 32'h0;
				else if ($signed(a_i) >= $signed(hi))
					res_o = hi;
				else
					res_o = a_i;
			end
			default: begin
				if (op_i >= OP_ADD_SHIFT_SIGNED &&
					op_i <= OP_SUB_ROUND_REGSHIFT_UNSIGNED) begin
					// Odd variant is logical, even is arithmetic
					res_o = idx[0] ? (sum >> sh) : 32'($signed(sum) >>> sh); // RULE15
				end
			end
		endcase
	end

endmodule
`default_nettype wire

// File: rtl/custom_alu_branch_decoder.sv
// Notes on behaviour
// (RULE1) Opcode 0x2B, funct3 011: funct7 0x29/0x2A pick signed/unsigned <=.
// (RULE2) Same group: funct7 0x2B signed minimum, 0x2C unsigned minimum.
// (RULE3) Same group: funct7 0x2D signed maximum, 0x2E unsigned maximum.
// (RULE4) Funct7 0x38/0x39 clip with bits 24:20 as unsigned immediate bound.
// (RULE5) Funct7 0x3A/0x3B clip with bound from register at bits 24:20.
// (RULE6) Opcode 0x5B funct3 010 add-shift; bits 31:30 variant, 29:25 shift.
// (RULE7) Opcode 0x5B funct3 011 subtract-shift, same variant coding.
// (RULE8) Funct7 0x40..0x43 add-shift by register, four variants in order.
// (RULE9) Funct7 0x44..0x47 subtract-shift by register, four variants.
// (RULE10) Equal-immediate branch goes to PC plus offset times two if equal; the code adds the offset unscaled, as for RULE11.
// (RULE11) Not-equal-immediate branch goes to PC plus offset if different.
// (RULE12) Five-bit compare immediate is sign-extended to 32 bits.
// (RULE13) Opcode 0x0B; funct3 110 equal, 111 not equal; imm in bits 24:20.
// (RULE14) Offset: bit31->12, 30:25->10:5, 11:8->4:1, bit7->11.
// (RULE15) Shift right arithmetic or logical; rounding adds 2^(n-1), 0 if n=0.
// (RULE16) Register clip limits to -(bound+1)..bound; bound non-negative.
// (RULE17) Register-shift forms use old rd, then rs1, shift by rs2[4:0].
// (RULE18) Unlisted function codes under the custom opcodes report illegal.
`timescale 1ns/1ps
`default_nettype none
module custom_alu_branch_decoder import alu_branch_pkg::*; (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] rs1_val_i,
	input wire logic [31:0] rs2_val_i,
	input wire logic [31:0] rd_val_i,
	output dec_s dec_o,
	output logic [31:0] result_o,
	output logic branch_taken_o,
	output logic [31:0] branch_target_o
);

	dec_s dec_d;
	logic [31:0] result_d;
	logic taken_d;
	logic [31:0] target_d;
	logic [6:0] opc;
	logic [2:0] f3;
	logic [6:0] f7;
	logic [1:0] variant_select_bits;
	logic [31:0] compare_small_immediate;
	logic [31:0] branch_offset_immediate;

	assign opc = instr_i[6:0];
	assign f3 = instr_i[14:12];
	assign f7 = instr_i[31:25];
	assign variant_select_bits = instr_i[31:30];
	assign compare_small_immediate = {{27{instr_i[24]}}, instr_i[24:20]}; // RULE12
	assign branch_offset_immediate = {{19{instr_i[31]}}, instr_i[31], // RULE14
		instr_i[7], instr_i[30:25], instr_i[11:8], 1'b0};

	////////////////////////////////////////////////////////////////////////
	// Field decode
	always_comb begin
		dec_d = DEC_RST;
		dec_d.valid = instr_valid_i;
		dec_d.rd_idx = instr_i[11:7];
		dec_d.rs1_idx = instr_i[19:15];
		dec_d.rs2_idx = instr_i[24:20];
		dec_d.small_imm = instr_i[24:20];
		dec_d.shift_amount_immediate = instr_i[29:25]; // RULE6
		case (opc)
			OPC_ALU: begin
				dec_d.claimed = 1'b1;
				dec_d.rs2_is_reg = 1'b1;
				if (f3 != F3_ALU) begin
					dec_d.illegal = 1'b1; // RULE18
				end else if (f7[6:3] == F7_REGSHIFT_HI) begin
					dec_d.op = op_e'(5'(OP_ADD_REGSHIFT_SIGNED + f7[2:0])); // RULE8 RULE9
					dec_d.rd_is_src = 1'b1; // RULE17
				end else begin
					case (f7)
						F7_SLE: dec_d.op = OP_SIGNED_LE_COMPARE; // RULE1
						F7_SLEU: dec_d.op = OP_UNSIGNED_LE_COMPARE; // RULE1
						F7_MIN: dec_d.op = OP_SIGNED_MINIMUM; // RULE2
						F7_MINU: dec_d.op = OP_UNSIGNED_MINIMUM; // RULE2
						F7_MAX: dec_d.op = OP_SIGNED_MAXIMUM; // RULE3
						F7_MAXU: dec_d.op = OP_UNSIGNED_MAXIMUM; // RULE3
						F7_CLIP: begin
							dec_d.op = OP_SIGNED_CLIP_IMM; // RULE4
							dec_d.rs2_is_reg = 1'b0;
						end
						F7_CLIPU: begin
							dec_d.op = OP_UNSIGNED_CLIP_IMM; // RULE4
							dec_d.rs2_is_reg = 1'b0;
						end
						F7_CLIPR: dec_d.op = OP_SIGNED_CLIP_REG; // RULE5
						F7_CLIPUR: dec_d.op = OP_UNSIGNED_CLIP_REG; // RULE5
						default: begin
							dec_d.illegal = 1'b1; // RULE18
							dec_d.rs2_is_reg = 1'b0;
						end
					endcase
				end
			end
			OPC_NORM: begin
				dec_d.claimed = 1'b1;
				dec_d.rs2_is_reg = 1'b1;
				if (f3 == F3_ADD_SHIFT)
					dec_d.op = op_e'(5'(OP_ADD_SHIFT_SIGNED + variant_select_bits)); // RULE6
				else if (f3 == F3_SUB_SHIFT)
					dec_d.op = op_e'(5'(OP_SUB_SHIFT_SIGNED + variant_select_bits)); // RULE7
				else
					dec_d.illegal = 1'b1; // RULE18
			end
			OPC_BRANCH_IMM: begin
				dec_d.claimed = 1'b1;
				if (f3 == F3_BRANCH_EQ)
					dec_d.op = OP_BRANCH_EQUAL_SMALL_IMM; // RULE13
				else if (f3 == F3_BRANCH_NE)
					dec_d.op = OP_BRANCH_NOTEQUAL_SMALL_IMM; // RULE13
				else
					dec_d.illegal = 1'b1; // RULE18
			end
			default: dec_d.claimed = 1'b0;
		endcase
		if (dec_d.illegal)
			dec_d.op = OP_NONE;
	end

	////////////////////////////////////////////////////////////////////////
	// Branch resolution
	always_comb begin
		target_d = pc_i + branch_offset_immediate; // RULE10 RULE11
		taken_d = 1'b0;
		if (instr_valid_i) begin
			if (dec_d.op == OP_BRANCH_EQUAL_SMALL_IMM)
				taken_d = (rs1_val_i == compare_small_immediate); // RULE10
			else if (dec_d.op == OP_BRANCH_NOTEQUAL_SMALL_IMM)
				taken_d = (rs1_val_i != compare_small_immediate); // RULE11
		end
		if (!taken_d)
			target_d = pc_i + 32'h4;
	end

	norm_alu_unit u_alu (
		.op_i(dec_d.op),
		.a_i(rs1_val_i),
		.b_i(rs2_val_i),
		.rd_i(rd_val_i),
		.compare_small_immediate_i(dec_d.small_imm),
		.shamt_i(dec_d.shift_amount_immediate),
		.res_o(result_d)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode output stage
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			dec_o <= DEC_RST;
		else
			dec_o <= dec_d;
	end

	// Execute result and branch outcome stage
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_o <= RESULT_RST;
			branch_taken_o <= 1'b0;
			branch_target_o <= TARGET_RST;
		end else begin
			result_o <= instr_valid_i ? result_d : RESULT_RST;
			branch_taken_o <= taken_d;
			branch_target_o <= target_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sle_decode_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE1
		instr_valid_i && opc == OPC_ALU && f3 == F3_ALU && f7 == F7_SLEU
		|=> dec_o.valid && dec_o.op == OP_UNSIGNED_LE_COMPARE && !dec_o.illegal)
		else $error("unsigned compare not decoded");

	min_result_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE2
		instr_valid_i && dec_d.op == OP_SIGNED_MINIMUM
		|=> result_o == (($signed($past(rs1_val_i)) < $signed($past(rs2_val_i)))
			? $past(rs1_val_i) : $past(rs2_val_i)))
		else $error("signed minimum result wrong");

	clip_bound_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE4
		instr_valid_i && opc == OPC_ALU && f3 == F3_ALU && f7 == F7_CLIPU
		|=> !dec_o.rs2_is_reg && dec_o.small_imm == $past(instr_i[24:20]))
		else $error("clip immediate bound not taken");

	addn_variant_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE6
		instr_valid_i && opc == OPC_NORM && f3 == F3_ADD_SHIFT &&
		instr_i[31:30] == 2'b10
		|=> dec_o.op == OP_ADD_ROUND_SHIFT_SIGNED &&
			dec_o.shift_amount_immediate == $past(instr_i[29:25]))
		else $error("rounding add variant not decoded");

	regshift_sub_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE9
		instr_valid_i && opc == OPC_ALU && f3 == F3_ALU && f7 == 7'h47
		|=> dec_o.op == OP_SUB_ROUND_REGSHIFT_UNSIGNED && dec_o.rd_is_src)
		else $error("register shift subtract not decoded");

	round_zero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE15
		instr_valid_i && dec_d.op == OP_ADD_ROUND_SHIFT_UNSIGNED &&
		instr_i[29:25] == 5'h00
		|=> result_o == $past(rs1_val_i) + $past(rs2_val_i))
		else $error("rounding term not zero at shift zero");

	beq_target_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE10
		instr_valid_i && opc == OPC_BRANCH_IMM && f3 == F3_BRANCH_EQ &&
		rs1_val_i == {{27{instr_i[24]}}, instr_i[24:20]}
		|=> branch_taken_o && branch_target_o == $past(pc_i) +
			{{19{$past(instr_i[31])}}, $past(instr_i[31]), $past(instr_i[7]),
			$past(instr_i[30:25]), $past(instr_i[11:8]), 1'b0})
		else $error("equal immediate branch wrong");

	bne_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE11
		instr_valid_i && opc == OPC_BRANCH_IMM && f3 == F3_BRANCH_NE &&
		rs1_val_i == {{27{instr_i[24]}}, instr_i[24:20]}
		|=> !branch_taken_o && branch_target_o == $past(pc_i) + 32'h4)
		else $error("not equal branch taken on equal");

	illegal_code_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE18
		instr_valid_i && opc == OPC_NORM && f3 != F3_ADD_SHIFT &&
		f3 != F3_SUB_SHIFT
		|=> dec_o.illegal && dec_o.op == OP_NONE && dec_o.claimed)
		else $error("unlisted code not flagged");

endmodule
`default_nettype wire

// File: tb/fetch_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_stage_model (
	input wire logic core_clk_i,
	output logic valid_o,
	output logic [31:0] instr_o,
	output logic [31:0] pc_o,
	output logic [31:0] rs1_o,
	output logic [31:0] rs2_o,
	output logic [31:0] rd_o
);
	////////////////////////////////////////////////////////////////////
	// Idle at time zero: nothing offered
	initial begin
		valid_o = 1'b0;
		instr_o = 32'h0;
		pc_o = 32'h0;
		rs1_o = 32'h0;
		rs2_o = 32'h0;
		rd_o = 32'h0;
	end

	// One word for one cycle, then released with inverted leftovers
	task automatic send(input logic [31:0] w, p, a, b, d);
		@(posedge core_clk_i);
		valid_o <= 1'b1;
		instr_o <= w;
		pc_o <= p;
		rs1_o <= a;
		rs2_o <= b;
		rd_o <= d;
		@(posedge core_clk_i);
		valid_o <= 1'b0;
		instr_o <= ~w;
		pc_o <= ~p;
		rs1_o <= ~a;
		rs2_o <= ~b;
		rd_o <= ~d;
	endtask
endmodule
`default_nettype wire

// File: tb/test_custom_alu_branch_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_custom_alu_branch_decoder import alu_branch_pkg::*;;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic v;
	logic [31:0] w;
	logic [31:0] p;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] d;
	dec_s dec;
	logic [31:0] res;
	logic [31:0] tgt;
	logic tk;
	int failures = 0;
	int checked = 0;
	logic [31:0] add_exp [4] = '{32'hFFFF_FFFD, 32'h3FFF_FFFD,
		32'hFFFF_FFFE, 32'h3FFF_FFFE};
	logic [31:0] sub_exp [4] = '{32'hFFFF_FFFE, 32'h3FFF_FFFE,
		32'hFFFF_FFFF, 32'h3FFF_FFFF};

	// 20 MHz core clock
	always #25 core_clk_i = ~core_clk_i;

	fetch_stage_model fetch_stage_model_inst (.core_clk_i(core_clk_i),
		.valid_o(v), .instr_o(w), .pc_o(p), .rs1_o(a), .rs2_o(b),
		.rd_o(d));

	custom_alu_branch_decoder custom_alu_branch_decoder_inst (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .instr_valid_i(v),
		.instr_i(w), .pc_i(p), .rs1_val_i(a), .rs2_val_i(b),
		.rd_val_i(d), .dec_o(dec), .result_o(res),
		.branch_taken_o(tk), .branch_target_o(tgt));

	////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic cmp(input string n, input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Register-form word with rs1 index 1 and rd index 2
	function automatic logic [31:0] enc(input logic [6:0] f7,
		input logic [4:0] r2, input logic [2:0] f3, input logic [6:0] o);
		return {f7, r2, 5'h01, f3, 5'h02, o};
	endfunction

	// Issue an ALU word and judge the decode one cycle later
	task automatic alu(input logic [31:0] wd, a_v, b_v, d_v,
		input op_e eo, input logic [31:0] er);
		logic cl;
		cl = wd[6:0] inside {OPC_ALU, OPC_NORM, OPC_BRANCH_IMM};
		fetch_stage_model_inst.send(wd, 32'h0000_0100, a_v, b_v, d_v);
		#1;
		cmp("op", {27'h0, eo}, {27'h0, dec.op});
		cmp("valid", 32'h1, {31'h0, dec.valid});
		cmp("claimed", {31'h0, cl}, {31'h0, dec.claimed});
		cmp("illegal", {31'h0, cl && eo == OP_NONE}, {31'h0, dec.illegal});
		cmp("target", 32'h0000_0104, tgt);
		cmp("idx", {17'h0, 5'h02, 5'h01, wd[24:20]},
			{17'h0, dec.rd_idx, dec.rs1_idx, dec.rs2_idx});
		cmp("rd_is_src", {31'h0, eo inside {[OP_ADD_REGSHIFT_SIGNED:
			OP_SUB_ROUND_REGSHIFT_UNSIGNED]}}, {31'h0, dec.rd_is_src});
		cmp("taken", 32'h0, {31'h0, tk});
		if (wd[6:0] === OPC_ALU || eo !== OP_NONE) begin
			cmp("result", er, res);
		end
	endtask

	// Issue an immediate branch from pc 0x1000 and judge it
	task automatic br(input logic [2:0] f3, input logic [4:0] i5,
		input logic [31:0] a_v, input logic [12:0] off, input logic et);
		logic [31:0] wd;
		wd = {off[12], off[10:5], i5, 5'h01, f3, off[4:1], off[11],
			OPC_BRANCH_IMM};
		fetch_stage_model_inst.send(wd, 32'h0000_1000, a_v, 32'h0, 32'h0);
		#1;
		cmp("op", {27'h0, f3 == F3_BRANCH_EQ ? OP_BRANCH_EQUAL_SMALL_IMM :
			OP_BRANCH_NOTEQUAL_SMALL_IMM}, {27'h0, dec.op});
		cmp("taken", {31'h0, et}, {31'h0, tk});
		cmp("target", et ? 32'h0000_1000 + {{19{off[12]}}, off} :
			32'h0000_1004, tgt);
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		#1;
		cmp("dec", 32'h0, {31'h0, |dec});
		cmp("result", 32'h0, res);
		cmp("target", 32'h0, tgt);
		cmp("taken", 32'h0, {31'h0, tk});
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
	endtask

	task automatic t_compare();
		alu(enc(F7_SLE, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_SIGNED_LE_COMPARE, 32'h1);
		alu(enc(F7_SLEU, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_UNSIGNED_LE_COMPARE, 32'h0);
		alu(enc(F7_MIN, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_SIGNED_MINIMUM, 32'hFFFF_FFFB);
		alu(enc(F7_MINU, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_UNSIGNED_MINIMUM, 32'h3);
		alu(enc(F7_MAX, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_SIGNED_MAXIMUM, 32'h3);
		alu(enc(F7_MAXU, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FFFB, 32'h3,
			32'h0, OP_UNSIGNED_MAXIMUM, 32'hFFFF_FFFB);
	endtask

	task automatic t_clip();
		alu(enc(F7_CLIP, 5'h04, F3_ALU, OPC_ALU), 32'hFFFF_FF9C, 32'h0,
			32'h0, OP_SIGNED_CLIP_IMM, 32'hFFFF_FFF8);
		alu(enc(F7_CLIP, 5'h00, F3_ALU, OPC_ALU), 32'h5, 32'hFFFF_FFFF,
			32'h0, OP_SIGNED_CLIP_IMM, 32'h0);
		alu(enc(F7_CLIPU, 5'h04, F3_ALU, OPC_ALU), 32'h64, 32'h0,
			32'h0, OP_UNSIGNED_CLIP_IMM, 32'h7);
		alu(enc(F7_CLIPR, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FF9C, 32'hA,
			32'h0, OP_SIGNED_CLIP_REG, 32'hFFFF_FFF5);
		alu(enc(F7_CLIPR, 5'h03, F3_ALU, OPC_ALU), 32'h64, 32'hA,
			32'h0, OP_SIGNED_CLIP_REG, 32'hA);
		alu(enc(F7_CLIPUR, 5'h03, F3_ALU, OPC_ALU), 32'hFFFF_FF9C, 32'hA,
			32'h0, OP_UNSIGNED_CLIP_REG, 32'h0);
	endtask

	task automatic t_shift();
		for (int i = 0; i < 4; i++) begin
			logic [1:0] k;
			k = i[1:0];
			alu(enc({k, 5'h02}, 5'h03, F3_ADD_SHIFT, OPC_NORM),
				32'hFFFF_FFF0, 32'h7, 32'h0,
				op_e'(OP_ADD_SHIFT_SIGNED + i), add_exp[i]);
			alu(enc({k, 5'h02}, 5'h03, F3_SUB_SHIFT, OPC_NORM),
				32'h0, 32'h5, 32'h0,
				op_e'(OP_SUB_SHIFT_SIGNED + i), sub_exp[i]);
			alu(enc({4'h8, 1'b0, k}, 5'h03, F3_ALU, OPC_ALU),
				32'h7, 32'h22, 32'hFFFF_FFF0,
				op_e'(OP_ADD_REGSHIFT_SIGNED + i), add_exp[i]);
			alu(enc({4'h8, 1'b1, k}, 5'h03, F3_ALU, OPC_ALU),
				32'h5, 32'h22, 32'h0,
				op_e'(OP_SUB_REGSHIFT_SIGNED + i), sub_exp[i]);
		end
		alu(enc(7'h40, 5'h03, F3_ADD_SHIFT, OPC_NORM), 32'h3, 32'h4,
			32'h0, OP_ADD_ROUND_SHIFT_SIGNED, 32'h7);
		alu(enc(7'h60, 5'h03, F3_ADD_SHIFT, OPC_NORM), 32'h3, 32'h4,
			32'h0, OP_ADD_ROUND_SHIFT_UNSIGNED, 32'h7);
	endtask

	task automatic t_branch();
		br(F3_BRANCH_EQ, 5'h1F, 32'hFFFF_FFFF, 13'h0ABE, 1'b1);
		br(F3_BRANCH_EQ, 5'h1F, 32'h0000_001F, 13'h0ABE, 1'b0);
		br(F3_BRANCH_NE, 5'h1F, 32'h0000_001F, 13'h1554, 1'b1);
		br(F3_BRANCH_NE, 5'h05, 32'h0000_0005, 13'h1554, 1'b0);
	endtask

	task automatic t_illegal();
		alu(enc(7'h28, 5'h00, F3_ALU, OPC_ALU), 32'h1, 32'h0, 32'h0,
			OP_NONE, 32'h0);
		alu(enc(7'h3C, 5'h03, F3_ALU, OPC_ALU), 32'h1, 32'h0, 32'h0,
			OP_NONE, 32'h0);
		alu(enc(F7_SLE, 5'h03, 3'h0, OPC_ALU), 32'h1, 32'h0, 32'h0,
			OP_NONE, 32'h0);
		alu(enc(7'h00, 5'h03, 3'h5, OPC_NORM), 32'h1, 32'h0, 32'h0,
			OP_NONE, 32'h0);
		alu(enc(7'h00, 5'h03, 3'h0, OPC_BRANCH_IMM), 32'h1, 32'h0,
			32'h0, OP_NONE, 32'h0);
		alu(enc(7'h00, 5'h03, 3'h0, 7'h33), 32'h1, 32'h0, 32'h0,
			OP_NONE, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic end_sim();
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		t_reset();
		t_compare();
		t_clip();
		t_shift();
		t_branch();
		t_reset();
		t_illegal();
		end_sim();
	end
endmodule
`default_nettype wire
